//--- hw/dio_pkg.sv
// Constants and types shared by the digital I/O line block
package dio_pkg;

  localparam int NUM_LINES = 4;
  localparam int NUM_USER = 4;
  localparam int WIDTH_BITS = 16;
  localparam int CLK_MHZ = 50;

  // Register offsets (word index on the plain register port)
  localparam logic [7:0] OFS_PIN_INDEX_SELECT = 8'h00;
  localparam logic [7:0] OFS_PIN_DIRECTION = 8'h01;
  localparam logic [7:0] OFS_AUX_SUPPLY_ENABLE = 8'h02;
  localparam logic [7:0] OFS_PIN_POLARITY_INVERT = 8'h03;
  localparam logic [7:0] OFS_PIN_LEVEL = 8'h04;
  localparam logic [7:0] OFS_PIN_LEVEL_VECTOR = 8'h05;
  localparam logic [7:0] OFS_FILTER_KIND_SELECT = 8'h06;
  localparam logic [7:0] OFS_FILTER_WIDTH_US = 8'h07;
  localparam logic [7:0] OFS_PIN_DRIVE_SOURCE = 8'h08;
  localparam logic [7:0] OFS_PIN_CIRCUIT_TYPE = 8'h09;
  localparam logic [7:0] OFS_SW_OUTPUT_INDEX = 8'h0A;
  localparam logic [7:0] OFS_SW_OUTPUT_BIT = 8'h0B;
  localparam logic [7:0] OFS_SW_OUTPUT_VECTOR = 8'h0C;
  localparam logic [7:0] OFS_EXT_SOURCE_IN = 8'h0D;

  // Reset values and the mask of lines able to switch an aux supply
  localparam logic [WIDTH_BITS-1:0] RST_FILTER_WIDTH_US = 16'h0000;
  localparam logic [3:0] RST_SW_OUTPUT_VECTOR = 4'h0;
  localparam logic [3:0] AUX_SUPPLY_CAPABLE = 4'h4;

  // Circuit type per line, packed two bits per line
  localparam logic [7:0] CIRCUIT_TYPE_MAP = 8'h80 | 8'h10 | 8'h04 | 8'h01;

  typedef enum logic [1:0] {CT_TRI_STATE, CT_OPTO_COUPLED, CT_OPEN_DRAIN} circuit_type_t;
  typedef enum logic {FK_GLITCH, FK_BOUNCE} filter_kind_t;

  // Source codes for a driven line
  localparam logic [4:0] SRC_OFF = 5'h00;
  localparam logic [4:0] SRC_LINE0 = 5'h01;
  localparam logic [4:0] SRC_USER0 = 5'h05;
  localparam logic [4:0] SRC_EXT0 = 5'h09;
  localparam logic [4:0] SRC_LAST = 5'h10;

endpackage

//--- hw/pin_sync.sv
// Two flip-flop synchroniser for a vector of pin inputs
`timescale 1ns/10ps
module pin_sync #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] stage1;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stage1 <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

//--- hw/line_filter.sv
// Glitch filter followed by bounce filter for one input line
`timescale 1ns/10ps
module line_filter #(
  parameter int CW = 22
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic raw_in,
  input wire logic [CW-1:0] glitch_cycles,
  input wire logic [CW-1:0] bounce_cycles,
  output logic filt_out
);
  logic glitch_state;
  logic [CW-1:0] glitch_cnt;
  logic [CW-1:0] bounce_cnt;
  logic bounce_busy;

  // Glitch: accept a new level only after it held for glitch_cycles
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      glitch_state <= 1'b0;
      glitch_cnt <= '0;
    end
    else if (raw_in == glitch_state)
      glitch_cnt <= '0;
    else if (glitch_cnt + 1'b1 >= glitch_cycles)
    begin
      glitch_state <= raw_in;
      glitch_cnt <= '0;
    end
    else
      glitch_cnt <= glitch_cnt + 1'b1;
  end

  assign bounce_busy = bounce_cnt != '0;

  // Bounce: pass first edge, then lock for bounce_cycles
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      filt_out <= 1'b0;
      bounce_cnt <= '0;
    end
    else if (bounce_busy)
      bounce_cnt <= bounce_cnt - 1'b1;
    else if (glitch_state != filt_out)
    begin
      filt_out <= glitch_state;
      bounce_cnt <= bounce_cycles;
    end
  end
endmodule

//--- hw/dio_lines.sv
// Per-line configuration, filtering and status for four digital I/O lines
//
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/10ps
module dio_lines
  import dio_pkg::*;
#(
  parameter int LINES = dio_pkg::NUM_LINES,
  parameter int CW = 22
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [3:0] pin_in,
  output logic [3:0] pin_out,
  output logic [3:0] pin_oe,
  output logic [3:0] aux_supply_on,
  input wire logic [3:0] ext_source,
  output logic [3:0] pin_level_vector,
  output logic [3:0] sw_output_vector
);
  import dio_pkg::*;

  // ------------------------------------------------------------
  // Configuration storage
  // ------------------------------------------------------------
  logic [1:0] pin_index_select;
  logic [3:0] pin_direction;
  logic [3:0] pin_polarity_invert;
  logic [3:0] aux_supply_enable;
  logic [3:0] filter_kind_select;
  logic [WIDTH_BITS-1:0] filter_width_us [0:7];
  logic [4:0] pin_drive_source [0:3];
  logic [1:0] sw_output_index;
  logic [3:0] sw_out;
  logic [3:0] synced;
  logic [3:0] filtered;
  logic [3:0] level;
  logic [3:0] drive_val;

  // Microseconds to clock cycles at the core rate
  function automatic logic [CW-1:0] us_to_cycles(input logic [WIDTH_BITS-1:0] us);
    logic [CW-1:0] c;
    c = CW'(us) * CW'(CLK_MHZ);
    return c;
  endfunction

  // Picks one bit of a four-bit vector by index
  function automatic logic pick4(input logic [3:0] v, input logic [1:0] i);
    return v[i];
  endfunction

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  wire sel_wr = reg_wr;
  wire [1:0] li = pin_index_select;
  wire [2:0] wi = {li, filter_kind_select[li]};
  wire wr_index = sel_wr && reg_addr == OFS_PIN_INDEX_SELECT;
  wire wr_dir = sel_wr && reg_addr == OFS_PIN_DIRECTION;
  wire wr_aux = sel_wr && reg_addr == OFS_AUX_SUPPLY_ENABLE;
  wire wr_inv = sel_wr && reg_addr == OFS_PIN_POLARITY_INVERT;
  wire wr_kind = sel_wr && reg_addr == OFS_FILTER_KIND_SELECT;
  wire wr_width = sel_wr && reg_addr == OFS_FILTER_WIDTH_US;
  wire wr_src = sel_wr && reg_addr == OFS_PIN_DRIVE_SOURCE;
  wire wr_uidx = sel_wr && reg_addr == OFS_SW_OUTPUT_INDEX;
  wire wr_ubit = sel_wr && reg_addr == OFS_SW_OUTPUT_BIT;
  wire wr_uvec = sel_wr && reg_addr == OFS_SW_OUTPUT_VECTOR;
  wire src_ok = reg_wdata[4:0] <= SRC_LAST;

  // ------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pin_index_select <= 2'h0;
      pin_direction <= 4'h0;
      pin_polarity_invert <= 4'h0;
      aux_supply_enable <= 4'h0;
      filter_kind_select <= 4'h0;
      sw_output_index <= 2'h0;
    end
    else
    begin
      if (wr_index)
        pin_index_select <= reg_wdata[1:0];
      if (wr_dir)
        pin_direction[li] <= reg_wdata[0];
      if (wr_aux && AUX_SUPPLY_CAPABLE[li])
        aux_supply_enable[li] <= reg_wdata[0];
      if (wr_inv)
        pin_polarity_invert[li] <= reg_wdata[0];
      if (wr_kind)
        filter_kind_select[li] <= reg_wdata[0];
      if (wr_uidx)
        sw_output_index <= reg_wdata[1:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      sw_out <= RST_SW_OUTPUT_VECTOR;
    else if (wr_uvec)
      sw_out <= reg_wdata[3:0];
    else if (wr_ubit)
      sw_out[sw_output_index] <= reg_wdata[0];
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < 8; i++)
        filter_width_us[i] <= RST_FILTER_WIDTH_US;
      for (int i = 0; i < 4; i++)
        pin_drive_source[i] <= SRC_OFF;
    end
    else
    begin
      if (wr_width)
        filter_width_us[wi] <= reg_wdata[WIDTH_BITS-1:0];
      if (wr_src && src_ok)
        pin_drive_source[li] <= reg_wdata[4:0];
    end
  end

  // ------------------------------------------------------------
  // Input path: sync, filter, invert
  // ------------------------------------------------------------
  pin_sync #(.W(4)) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .async_in(pin_in),
    .sync_out(synced)
  );

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_line
      line_filter #(.CW(CW)) u_filt (
        .clk(clk),
        .arst_n(arst_n),
        .raw_in(synced[g]),
        .glitch_cycles(us_to_cycles(filter_width_us[2*g])),
        .bounce_cycles(us_to_cycles(filter_width_us[2*g+1])),
        .filt_out(filtered[g])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // Output path: source select and level
  // ------------------------------------------------------------
  function automatic logic src_value(input logic [4:0] s, input logic [3:0] lv,
                                     input logic [3:0] uo, input logic [3:0] ex);
    logic v;
    v = 1'b0;
    if (s >= SRC_LINE0 && s < SRC_USER0)
      v = lv[2'(s - SRC_LINE0)];
    else if (s >= SRC_USER0 && s < SRC_EXT0)
      v = uo[2'(s - SRC_USER0)];
    else if (s >= SRC_EXT0 && s <= SRC_LAST)
      v = ex[2'(s - SRC_EXT0)];
    return v;
  endfunction

  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      drive_val[i] = src_value(pin_drive_source[i], pin_level_vector, sw_out, ext_source);
      // Level reflects the driven value on outputs, filtered pin on inputs
      level[i] = pin_direction[i] ?
                 (drive_val[i] ^ pin_polarity_invert[i]) :
                 (filtered[i] ^ pin_polarity_invert[i]);
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pin_out <= 4'h0;
      pin_oe <= 4'h0;
      aux_supply_on <= 4'h0;
      pin_level_vector <= 4'h0;
      sw_output_vector <= RST_SW_OUTPUT_VECTOR;
    end
    else
    begin
      pin_out <= drive_val ^ pin_polarity_invert;
      pin_oe <= pin_direction;
      aux_supply_on <= aux_supply_enable & AUX_SUPPLY_CAPABLE;
      pin_level_vector <= level;
      sw_output_vector <= sw_out;
    end
  end

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0;
    case (reg_addr)
      OFS_PIN_INDEX_SELECT: rd_mux[1:0] = pin_index_select;
      OFS_PIN_DIRECTION: rd_mux[0] = pick4(pin_direction, li);
      OFS_AUX_SUPPLY_ENABLE: rd_mux[0] = pick4(aux_supply_enable, li);
      OFS_PIN_POLARITY_INVERT: rd_mux[0] = pick4(pin_polarity_invert, li);
      OFS_PIN_LEVEL: rd_mux[0] = pick4(pin_level_vector, li);
      OFS_PIN_LEVEL_VECTOR: rd_mux[3:0] = pin_level_vector;
      OFS_FILTER_KIND_SELECT: rd_mux[0] = pick4(filter_kind_select, li);
      OFS_FILTER_WIDTH_US: rd_mux[WIDTH_BITS-1:0] = filter_width_us[wi];
      OFS_PIN_DRIVE_SOURCE: rd_mux[4:0] = pin_drive_source[li];
      OFS_PIN_CIRCUIT_TYPE: rd_mux[1:0] = CIRCUIT_TYPE_MAP[2*li +: 2];
      OFS_SW_OUTPUT_INDEX: rd_mux[1:0] = sw_output_index;
      OFS_SW_OUTPUT_BIT: rd_mux[0] = pick4(sw_out, sw_output_index);
      OFS_SW_OUTPUT_VECTOR: rd_mux[3:0] = sw_out;
      OFS_EXT_SOURCE_IN: rd_mux[3:0] = ext_source;
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata <= 32'h0;
    else if (reg_rd)
      reg_rdata <= rd_mux;
    else
      reg_rdata <= 32'h0;
  end

endmodule

//--- verif/dio_lines_assertions.sv
// Port checker for the digital I/O line block
`timescale 1ns/10ps
module dio_lines_checker
  import dio_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [3:0] pin_in,
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe,
  input wire logic [3:0] aux_supply_on,
  input wire logic [3:0] ext_source,
  input wire logic [3:0] pin_level_vector,
  input wire logic [3:0] sw_output_vector
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire vec_wr = reg_wr && reg_addr == OFS_SW_OUTPUT_VECTOR;
  wire dir_wr = reg_wr && reg_addr == OFS_PIN_DIRECTION;
  logic [3:0] last_vec;
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      last_vec <= 4'h0;
    else if (vec_wr)
      last_vec <= reg_wdata[3:0];
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_read_idle_zero: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data not zero outside read");
  a_level_bit_only: assert property (reg_rd && reg_addr == OFS_PIN_LEVEL
    |=> reg_rdata[31:1] == 31'h0)
    else $error("level read has upper bits");
  a_level_vector_read: assert property (reg_rd && reg_addr == OFS_PIN_LEVEL_VECTOR
    |=> reg_rdata == {28'h0, $past(pin_level_vector)})
    else $error("level vector read mismatch");
  a_vector_write_all: assert property ($past(vec_wr, 2) && !$past(reg_wr)
    |-> sw_output_vector == last_vec)
    else $error("output vector not updated");
  a_aux_capable_only: assert property ((aux_supply_on & ~AUX_SUPPLY_CAPABLE) == 4'h0)
    else $error("aux supply on incapable line");
  a_dir_change_cause: assert property ($changed(pin_oe) |-> $past(dir_wr) || $past(dir_wr, 2))
    else $error("direction changed without write");
  a_ctype_upper_zero: assert property (reg_rd && reg_addr == OFS_PIN_CIRCUIT_TYPE
    |=> reg_rdata[31:2] == 30'h0)
    else $error("circuit type read has upper bits");
  a_sw_bit_only: assert property (reg_rd && reg_addr == OFS_SW_OUTPUT_BIT
    |=> reg_rdata[31:1] == 31'h0)
    else $error("output bit read has upper bits");
endmodule

//--- verif/dio_far_side.sv
// External circuits on the connector pins
`timescale 1ns/10ps
module dio_far_side (
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe,
  input wire logic [3:0] drive,
  output logic [3:0] pin_in
);
  // A driven pin reads back its own level, an input pin the outside level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & drive);
endmodule

//--- verif/dio_lines_bench.sv
// Register-level test of the digital I/O line block
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_total++; \
  $display("wrong value at %0t: %h not %h", $time, a, b); end end
module dio_lines_bench;
  import dio_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata, d;
  logic [3:0] pin_in, pin_out, pin_oe, aux_supply_on, pin_level_vector, sw_output_vector;
  logic [3:0] ext_source = 4'h0;
  logic [3:0] drive = 4'h0;
  int err_total = 0;
  int comparisons = 0;
  dio_lines dio_lines_i (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .aux_supply_on(aux_supply_on), .ext_source(ext_source),
    .pin_level_vector(pin_level_vector), .sw_output_vector(sw_output_vector));
  dio_far_side dio_far_side_i (.pin_out(pin_out), .pin_oe(pin_oe), .drive(drive), .pin_in(pin_in));
  initial
  begin
    forever #10 clk = ~clk;
  end
  // ------------------------------------------------------------
  // Bus and pin tasks
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic drv(input logic [3:0] v, input int n);
    @(posedge clk);
    drive <= v;
    cyc(n);
  endtask
  task automatic wrap_up;
    if (err_total == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    rd(OFS_SW_OUTPUT_VECTOR);
    `CHK(d[3:0], RST_SW_OUTPUT_VECTOR)
    rd(OFS_PIN_LEVEL_VECTOR);
    `CHK(d, 32'h0)
    rd(8'h3F);
    `CHK(d, 32'h0)
    wr(OFS_SW_OUTPUT_VECTOR, 32'hA);
    rd(OFS_SW_OUTPUT_VECTOR);
    `CHK(d, 32'hA)
    `CHK(sw_output_vector, 4'hA)
    wr(OFS_SW_OUTPUT_VECTOR, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      wr(OFS_SW_OUTPUT_INDEX, 32'(i));
      wr(OFS_SW_OUTPUT_BIT, 32'h1);
      rd(OFS_SW_OUTPUT_BIT);
      `CHK(d, 32'h1)
      `CHK(sw_output_vector, 4'((1 << (i + 1)) - 1))
    end
    wr(OFS_SW_OUTPUT_INDEX, 32'h2);
    wr(OFS_SW_OUTPUT_BIT, 32'h0);
    cyc(2);
    `CHK(sw_output_vector, 4'hB)
    wr(OFS_PIN_INDEX_SELECT, 32'h1);
    wr(OFS_PIN_DRIVE_SOURCE, 32'(SRC_USER0) + 32'h1);
    cyc(2);
    `CHK(pin_oe, 4'h0)
    wr(OFS_PIN_DIRECTION, 32'h1);
    cyc(4);
    `CHK(pin_oe, 4'h2)
    `CHK(pin_out[1], 1'b1)
    rd(OFS_PIN_DIRECTION);
    `CHK(d, 32'h1)
    rd(OFS_PIN_LEVEL);
    `CHK(d, 32'h1)
    wr(OFS_PIN_POLARITY_INVERT, 32'h1);
    cyc(2);
    `CHK(pin_out[1], 1'b0)
    @(posedge clk);
    ext_source <= 4'h4;
    wr(OFS_PIN_INDEX_SELECT, 32'h2);
    wr(OFS_PIN_DRIVE_SOURCE, 32'(SRC_EXT0) + 32'h2);
    wr(OFS_PIN_DIRECTION, 32'h1);
    cyc(2);
    `CHK(pin_out[2], 1'b1)
    rd(OFS_EXT_SOURCE_IN);
    `CHK(d, 32'h4)
    for (int i = 0; i < 4; i++)
    begin
      wr(OFS_PIN_INDEX_SELECT, 32'(i));
      wr(OFS_AUX_SUPPLY_ENABLE, 32'h1);
      wr(OFS_PIN_CIRCUIT_TYPE, 32'h3);
      rd(OFS_PIN_CIRCUIT_TYPE);
      `CHK(d, 32'(CIRCUIT_TYPE_MAP[2*i +: 2]))
    end
    cyc(2);
    `CHK(aux_supply_on, AUX_SUPPLY_CAPABLE)
    wr(OFS_FILTER_WIDTH_US, 32'h1);
    drv(4'h8, CLK_MHZ / 2);
    drv(4'h0, CLK_MHZ + 10);
    `CHK(pin_level_vector[3], 1'b0)
    drv(4'h8, CLK_MHZ - 10);
    `CHK(pin_level_vector[3], 1'b0)
    cyc(20);
    `CHK(pin_level_vector[3], 1'b1)
    rd(OFS_PIN_LEVEL);
    `CHK(d, 32'h1)
    wr(OFS_PIN_POLARITY_INVERT, 32'h1);
    cyc(4);
    `CHK(pin_level_vector[3], 1'b0)
    wr(OFS_PIN_INDEX_SELECT, 32'h0);
    wr(OFS_FILTER_KIND_SELECT, 32'h1);
    wr(OFS_FILTER_WIDTH_US, 32'h1);
    rd(OFS_FILTER_WIDTH_US);
    `CHK(d, 32'h1)
    wr(OFS_FILTER_KIND_SELECT, 32'h0);
    rd(OFS_FILTER_WIDTH_US);
    `CHK(d, 32'h0)
    drv(4'h9, 8);
    `CHK(pin_level_vector[0], 1'b1)
    drv(4'h8, 10);
    `CHK(pin_level_vector[0], 1'b1)
    cyc(CLK_MHZ + 10);
    `CHK(pin_level_vector[0], 1'b0)
    wrap_up();
  end
endmodule
bind dio_lines dio_lines_checker dio_lines_checker_i (.clk(clk), .arst_n(arst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
  .aux_supply_on(aux_supply_on), .ext_source(ext_source),
  .pin_level_vector(pin_level_vector), .sw_output_vector(sw_output_vector));
